// ### pkg/lrc_pkg.sv
// Constants for the light result and configuration register bank.
// Assumes a single 250 MHz clock shared by the byte front end and the bank.
package lrc_pkg;

  localparam int          LRC_CLK_MHZ        = 250;
  localparam int          LRC_CONV_SHORT_MS  = 100;
  localparam int          LRC_CONV_LONG_MS   = 800;
  localparam int          LRC_CONV_SHORT_CYC = LRC_CONV_SHORT_MS * 1000 * LRC_CLK_MHZ;
  localparam int          LRC_CONV_LONG_CYC  = LRC_CONV_LONG_MS * 1000 * LRC_CLK_MHZ;

  localparam int          LRC_COUNT_W        = 23;
  localparam int          LRC_MANT_W         = 12;
  localparam int          LRC_EXP_W          = 4;

  localparam logic [7:0]  LRC_PTR_RESULT     = 8'h00;
  localparam logic [7:0]  LRC_PTR_CONFIG     = 8'h01;
  localparam logic [7:0]  LRC_PTR_RST        = 8'h00;
  localparam logic [7:0]  LRC_UNMAPPED_BYTE  = 8'h00;

  localparam logic [15:0] LRC_RESULT_RST     = 16'h0000;
  localparam logic [15:0] LRC_CONFIG_RST     = 16'hc810;
  localparam logic [15:0] LRC_CFG_WR_MASK    = 16'hfe1f;

  localparam int          LRC_EXP_LSB        = 12;
  localparam int          LRC_RN_LSB         = 12;
  localparam int          LRC_CT_BIT         = 11;
  localparam int          LRC_MODE_LSB       = 9;
  localparam int          LRC_OVF_BIT        = 8;
  localparam int          LRC_CRF_BIT        = 7;
  localparam int          LRC_ME_BIT         = 2;

  localparam logic [3:0]  LRC_RN_AUTO        = 4'hc;
  localparam logic [3:0]  LRC_EXP_MAX        = 4'hb;
  localparam logic [1:0]  LRC_MODE_OFF       = 2'h0;
  localparam logic [1:0]  LRC_MODE_SINGLE    = 2'h1;
  localparam logic [11:0] LRC_MANT_FULL      = 12'hfff;

  typedef enum logic [1:0] {
    LRC_BYTE_PTR,
    LRC_BYTE_MSB,
    LRC_BYTE_LSB,
    LRC_BYTE_DONE
  } lrc_wr_phase_t;

  typedef enum logic {
    LRC_ST_IDLE,
    LRC_ST_RUN
  } lrc_state_t;

endpackage

// ### rtl/lrc_conv_timer.sv
// Conversion interval timer for the light register bank.
// Assumes start and abort come from logic on the same clock.
module lrc_conv_timer
  import lrc_pkg::*;
#(
  parameter int SHORT_CYC = LRC_CONV_SHORT_CYC,
  parameter int LONG_CYC  = LRC_CONV_LONG_CYC
)
(
  input  wire logic clock_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  input  wire logic abort_i,
  input  wire logic long_i,
  output logic      busy_o,
  output logic      done_o
);

  initial
  begin
    if (SHORT_CYC < 1 || LONG_CYC < 1)
      $error("lrc_conv_timer: cycle counts must be at least one");
  end

  logic [31:0] count_r;
  logic [31:0] limit_r;
  logic        busy_r;
  logic        done_r;
  wire  logic  at_end = busy_r && (count_r == limit_r - 32'h1);

  // Start restarts even while running; abort alone cancels
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      count_r <= 32'h0;
      limit_r <= 32'h1;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (start_i)
      begin
        count_r <= 32'h0;
        limit_r <= long_i ? 32'(LONG_CYC) : 32'(SHORT_CYC);
        busy_r  <= 1'b1;
      end
      else if (abort_i)
        busy_r <= 1'b0;
      else if (at_end)
      begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
      else if (busy_r)
        count_r <= count_r + 32'h1;
    end
  end

  assign busy_o = busy_r;
  assign done_o = done_r;

endmodule

// ### rtl/lrc_light_regs.sv
// Result and configuration registers of a light-to-digital converter.
// Assumes a byte-level serial target front end and a light counter on this clock.
//
// Functional notes
// - Result register: exponent in upper four bits, mantissa in lower twelve.
// - Result always holds outcome of latest completed conversion.
// - Mantissa is unsigned straight binary, zero to active full-scale.
// - Result reads all zeros after reset.
// - Lux equals 0.01 times two to exponent times mantissa.
// - Exponent suppress with manual range forces reported exponent to zero.
// - Configuration write cancels a running conversion immediately.
// - After configuration write, new settings calling for conversion start one.
// - Configuration register resets to c810.
// - Bits 15:9 and 4:0 read/write; bits 8:5 read-only status.
// - Range field 15:12 selects full-scale with exponent code table.
// - Range code 1100 selects automatic ranging; chosen range shown in exponent.
// - Power-up range field holds 1100, automatic ranging.
// - Registers cross the bus as two bytes, most significant first.
// - Conversion-time bit: zero gives 100 ms, one gives 800 ms.
// - Mode 00 shutdown, 01 single, else continuous; single clears to 00.
module lrc_light_regs
  import lrc_pkg::*;
#(
  parameter int COUNT_W   = LRC_COUNT_W,
  parameter int SHORT_CYC = LRC_CONV_SHORT_CYC,
  parameter int LONG_CYC  = LRC_CONV_LONG_CYC
)
(
  input  wire logic               clock_i,
  input  wire logic               resetn_i,
  input  wire logic               bus_start_i,
  input  wire logic               bus_wr_valid_i,
  input  wire logic [7:0]         bus_wr_data_i,
  input  wire logic               bus_rd_req_i,
  output logic [7:0]              bus_rd_data_o,
  output logic                    bus_rd_valid_o,
  input  wire logic [COUNT_W-1:0] light_count_i,
  output logic                    conv_active_o,
  output logic [3:0]              conv_range_o
);

  initial
  begin
    if (COUNT_W < LRC_COUNT_W)
      $error("lrc_light_regs: COUNT_W too small for the widest range");
  end

  // Light count scaled to a range; saturates at full scale
  function automatic logic [11:0] scale_count(input logic [COUNT_W-1:0] cnt,
                                              input logic [3:0]         exp);
    logic [COUNT_W-1:0] sh;
    sh = cnt >> exp;
    if (sh > COUNT_W'(LRC_MANT_FULL))
      scale_count = LRC_MANT_FULL;
    else
      scale_count = sh[11:0];
  endfunction

  // True when the count exceeds the full scale of a range
  function automatic logic over_range(input logic [COUNT_W-1:0] cnt,
                                      input logic [3:0]         exp);
    logic [COUNT_W-1:0] sh;
    sh = cnt >> exp;
    over_range = (sh > COUNT_W'(LRC_MANT_FULL));
  endfunction

  // Smallest range holding the count, else the widest
  function automatic logic [3:0] pick_range(input logic [COUNT_W-1:0] cnt);
    logic [3:0] e;
    e = LRC_EXP_MAX;
    for (int i = int'(LRC_EXP_MAX); i >= 0; i--)
    begin
      if (!over_range(cnt, 4'(i)))
        e = 4'(i);
    end
    pick_range = e;
  endfunction

  logic [15:0]   result_r;
  logic [15:0]   cfg_r;
  logic          ovf_r;
  logic          crf_r;
  logic [7:0]    ptr_r;
  lrc_wr_phase_t wr_phase_r;
  logic [7:0]    wr_msb_r;
  logic          rd_lsb_r;
  logic [7:0]    rd_hold_r;
  logic [7:0]    rd_data_r;
  logic          rd_valid_r;
  lrc_state_t    state_r;
  lrc_state_t    state_nxt;
  logic [15:0]   cfg_nxt;
  logic          ovf_nxt;
  logic          crf_nxt;
  logic [7:0]    ptr_nxt;
  lrc_wr_phase_t wr_phase_nxt;
  logic [7:0]    wr_msb_nxt;
  logic          rd_lsb_nxt;
  logic [7:0]    rd_hold_nxt;
  logic [7:0]    rd_data_nxt;

  // Configuration field decode
  wire logic [3:0] rn_w       = cfg_r[LRC_RN_LSB +: LRC_EXP_W];
  wire logic [1:0] mode_w     = cfg_r[LRC_MODE_LSB +: 2];
  wire logic       long_w     = cfg_r[LRC_CT_BIT];
  wire logic       me_w       = cfg_r[LRC_ME_BIT];
  wire logic       auto_w     = (rn_w == LRC_RN_AUTO);

  // Configuration read value: status bits from their own flops
  wire logic [15:0] cfg_rd_w  = (cfg_r & LRC_CFG_WR_MASK)
                              | (16'(ovf_r) << LRC_OVF_BIT)
                              | (16'(crf_r) << LRC_CRF_BIT);

  // Byte write decode
  wire logic        ptr_byte_w  = bus_wr_valid_i && (wr_phase_r == LRC_BYTE_PTR);
  wire logic        msb_byte_w  = bus_wr_valid_i && (wr_phase_r == LRC_BYTE_MSB);
  wire logic        lsb_byte_w  = bus_wr_valid_i && (wr_phase_r == LRC_BYTE_LSB);
  wire logic        cfg_write_w = lsb_byte_w && (ptr_r == LRC_PTR_CONFIG);
  wire logic [15:0] wr_word_w   = {wr_msb_r, bus_wr_data_i};

  // New configuration, read-only status bits kept out
  wire logic [15:0] cfg_new_w   = wr_word_w & LRC_CFG_WR_MASK;
  wire logic [1:0]  new_mode_w  = cfg_new_w[LRC_MODE_LSB +: 2];
  wire logic        new_long_w  = cfg_new_w[LRC_CT_BIT];

  // Conversion control
  wire logic        timer_busy_w;
  wire logic        timer_done_w;
  wire logic        abort_w     = cfg_write_w;
  wire logic        restart_w   = (cfg_write_w && (new_mode_w != LRC_MODE_OFF))
                                || (timer_done_w && !cfg_write_w
                                    && (mode_w != LRC_MODE_OFF)
                                    && (mode_w != LRC_MODE_SINGLE));
  wire logic        start_long_w = cfg_write_w ? new_long_w : long_w;

  // Result formation at conversion end
  wire logic [3:0]  auto_exp_w  = pick_range(light_count_i);
  wire logic [3:0]  conv_exp_w  = auto_w ? auto_exp_w : rn_w;
  wire logic [11:0] conv_mant_w = scale_count(light_count_i, conv_exp_w);
  wire logic        conv_ovf_w  = over_range(light_count_i, conv_exp_w);
  wire logic        suppress_w  = me_w && (rn_w < LRC_RN_AUTO);
  wire logic [3:0]  rep_exp_w   = suppress_w ? 4'h0 : conv_exp_w;
  wire logic [15:0] result_nxt  = {rep_exp_w, conv_mant_w};

  // Read byte selection
  wire logic [15:0] rd_word_w   = (ptr_r == LRC_PTR_RESULT) ? result_r
                                : (ptr_r == LRC_PTR_CONFIG) ? cfg_rd_w
                                : {LRC_UNMAPPED_BYTE, LRC_UNMAPPED_BYTE};
  wire logic        cfg_lsb_rd_w = bus_rd_req_i && rd_lsb_r && (ptr_r == LRC_PTR_CONFIG);

  lrc_conv_timer #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_timer (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .start_i  (restart_w),
    .abort_i  (abort_w),
    .long_i   (start_long_w),
    .busy_o   (timer_busy_w),
    .done_o   (timer_done_w)
  );

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      LRC_ST_IDLE:
        if (restart_w)
          state_nxt = LRC_ST_RUN;
      LRC_ST_RUN:
        if ((abort_w || timer_done_w) && !restart_w)
          state_nxt = LRC_ST_IDLE;
      default:
        state_nxt = LRC_ST_IDLE;
    endcase
  end

  // Pointer and write phase next values
  always_comb
  begin
    ptr_nxt      = ptr_r;
    wr_phase_nxt = wr_phase_r;
    wr_msb_nxt   = wr_msb_r;
    if (bus_start_i)
      wr_phase_nxt = LRC_BYTE_PTR;
    else if (ptr_byte_w)
    begin
      ptr_nxt      = bus_wr_data_i;
      wr_phase_nxt = LRC_BYTE_MSB;
    end
    else if (msb_byte_w)
    begin
      wr_msb_nxt   = bus_wr_data_i;
      wr_phase_nxt = LRC_BYTE_LSB;
    end
    else if (lsb_byte_w)
      wr_phase_nxt = LRC_BYTE_DONE;
  end

  // Pointer and write phase
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ptr_r      <= LRC_PTR_RST;
      wr_phase_r <= LRC_BYTE_PTR;
      wr_msb_r   <= 8'h00;
    end
    else
    begin
      ptr_r      <= ptr_nxt;
      wr_phase_r <= wr_phase_nxt;
      wr_msb_r   <= wr_msb_nxt;
    end
  end

  // Configuration next value; write beats single-shot clear
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (cfg_write_w)
      cfg_nxt = cfg_new_w;
    else if (timer_done_w && (mode_w == LRC_MODE_SINGLE))
      cfg_nxt[LRC_MODE_LSB +: 2] = LRC_MODE_OFF;
  end

  // Configuration register
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cfg_r <= LRC_CONFIG_RST & LRC_CFG_WR_MASK;
    else
      cfg_r <= cfg_nxt;
  end

  // Status flag next values; a completion beats the read clear
  always_comb
  begin
    ovf_nxt = ovf_r;
    crf_nxt = crf_r;
    if (timer_done_w)
    begin
      ovf_nxt = conv_ovf_w;
      crf_nxt = 1'b1;
    end
    else if (cfg_lsb_rd_w)
      crf_nxt = 1'b0;
  end

  // Result and status flags
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      result_r <= LRC_RESULT_RST;
      ovf_r    <= LRC_CONFIG_RST[LRC_OVF_BIT];
      crf_r    <= LRC_CONFIG_RST[LRC_CRF_BIT];
    end
    else
    begin
      if (timer_done_w)
        result_r <= result_nxt;
      ovf_r <= ovf_nxt;
      crf_r <= crf_nxt;
    end
  end

  // Read byte next values: word captured with the first byte
  always_comb
  begin
    rd_lsb_nxt  = rd_lsb_r;
    rd_hold_nxt = rd_hold_r;
    rd_data_nxt = rd_data_r;
    if (bus_start_i)
      rd_lsb_nxt = 1'b0;
    else if (bus_rd_req_i)
    begin
      rd_lsb_nxt  = !rd_lsb_r;
      rd_data_nxt = rd_lsb_r ? rd_hold_r : rd_word_w[15:8];
      if (!rd_lsb_r)
        rd_hold_nxt = rd_word_w[7:0];
    end
  end

  // Read bytes: most significant first, word held across the pair
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rd_lsb_r   <= 1'b0;
      rd_hold_r  <= 8'h00;
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_lsb_r   <= rd_lsb_nxt;
      rd_hold_r  <= rd_hold_nxt;
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= bus_rd_req_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_r <= LRC_ST_IDLE;
    else
      state_r <= state_nxt;
  end

  assign bus_rd_data_o  = rd_data_r;
  assign bus_rd_valid_o = rd_valid_r;
  assign conv_active_o  = (state_r == LRC_ST_RUN) && timer_busy_w;
  assign conv_range_o   = conv_exp_w;

endmodule

// ### testbench/lrc_light_regs_assertions.sv
// Checker for the light register bank ports.
// Assumes it is bound to every lrc_light_regs instance.
module lrc_light_regs_assertions
#(
  parameter int COUNT_W  = 23,
  parameter int LONG_CYC = 50
)
(
  input wire logic               clock_i,
  input wire logic               resetn_i,
  input wire logic               bus_start_i,
  input wire logic               bus_wr_valid_i,
  input wire logic [7:0]         bus_wr_data_i,
  input wire logic               bus_rd_req_i,
  input wire logic [7:0]         bus_rd_data_o,
  input wire logic               bus_rd_valid_o,
  input wire logic [COUNT_W-1:0] light_count_i,
  input wire logic               conv_active_o,
  input wire logic [3:0]         conv_range_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] ph_r;
  logic [7:0] ptr_r;
  logic [7:0] msb_r;
  int         cnt_r;
  wire        byte_w = bus_wr_valid_i && !bus_start_i;
  wire        cfg_wr = byte_w && ph_r == 2'h2 && ptr_r == 8'h01;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ph_r  <= 2'h0;
      ptr_r <= 8'h00;
      msb_r <= 8'h00;
      cnt_r <= 0;
    end
    else
    begin
      ph_r  <= bus_start_i ? 2'h0 : ph_r + {1'b0, byte_w && ph_r != 2'h3};
      ptr_r <= (byte_w && ph_r == 2'h0) ? bus_wr_data_i : ptr_r;
      msb_r <= (byte_w && ph_r == 2'h1) ? bus_wr_data_i : msb_r;
      cnt_r <= (conv_active_o && !cfg_wr) ? cnt_r + 1 : 0;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  AST_RD_ANSWER: assert property (bus_rd_req_i |=> bus_rd_valid_o)
    else $error("read byte not answered");
  AST_RD_NO_SPUR: assert property (!bus_rd_req_i |=> !bus_rd_valid_o)
    else $error("read valid without request");
  AST_RD_HOLD: assert property (!bus_rd_req_i |=> $stable(bus_rd_data_o))
    else $error("read byte changed without request");
  AST_CFG_START: assert property (cfg_wr && msb_r[2:1] != 2'h0 |=> conv_active_o)
    else $error("conversion not started by write");
  AST_CFG_ABORT: assert property (cfg_wr && msb_r[2:1] == 2'h0 |=> !conv_active_o)
    else $error("conversion not aborted by write");
  AST_MAN_RANGE: assert property (cfg_wr && msb_r[7:4] < 4'hc |=> conv_range_o == msb_r[7:4])
    else $error("manual range not applied");
  AST_RANGE_MAX: assert property (conv_range_o <= 4'hb)
    else $error("range above top code");
  AST_CONV_LEN: assert property (cnt_r <= LONG_CYC)
    else $error("conversion runs too long");

  COV_CFG_WR: cover property (cfg_wr);
  COV_DONE: cover property ($fell(conv_active_o));
  COV_RD_PAIR: cover property (bus_rd_valid_o ##1 bus_rd_valid_o);
endmodule

bind lrc_light_regs lrc_light_regs_assertions #(
  .COUNT_W (COUNT_W),
  .LONG_CYC(LONG_CYC)
) i_lrc_light_regs_assertions (
  .clock_i       (clock_i),
  .resetn_i      (resetn_i),
  .bus_start_i   (bus_start_i),
  .bus_wr_valid_i(bus_wr_valid_i),
  .bus_wr_data_i (bus_wr_data_i),
  .bus_rd_req_i  (bus_rd_req_i),
  .bus_rd_data_o (bus_rd_data_o),
  .bus_rd_valid_o(bus_rd_valid_o),
  .light_count_i (light_count_i),
  .conv_active_o (conv_active_o),
  .conv_range_o  (conv_range_o)
);

// ### testbench/lrc_host_model.sv
// Byte-level serial host driving the register bank.
// Assumes the caller runs after reset release.
module lrc_host_model
(
  input  wire logic clock_i,
  output logic       bus_start_o,
  output logic       bus_wr_valid_o,
  output logic [7:0] bus_wr_data_o,
  output logic       bus_rd_req_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    bus_start_o    = 1'b0;
    bus_wr_valid_o = 1'b0;
    bus_wr_data_o  = 8'h00;
    bus_rd_req_o   = 1'b0;
  end

  task automatic step();
    @(posedge clock_i);
    #1;
  endtask

  task automatic begin_tr();
    step();
    bus_start_o    = 1'b1;
    bus_wr_valid_o = 1'b0;
  endtask

  task automatic put(input logic [7:0] b);
    step();
    bus_start_o    = 1'b0;
    bus_wr_valid_o = 1'b1;
    bus_wr_data_o  = b;
  endtask

  task automatic idle();
    step();
    bus_start_o    = 1'b0;
    bus_wr_valid_o = 1'b0;
    bus_rd_req_o   = 1'b0;
    bus_wr_data_o  = ~bus_wr_data_o;
  endtask

  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] val);
    begin_tr();
    put(ptr);
    put(val[15:8]);
    put(val[7:0]);
    idle();
  endtask

  task automatic read_reg(input logic [7:0] ptr);
    begin_tr();
    put(ptr);
    idle();
    begin_tr();
    step();
    bus_start_o  = 1'b0;
    bus_rd_req_o = 1'b1;
    step();
    idle();
  endtask
endmodule

// ### testbench/lrc_light_regs_tb.sv
// Self-checking bench for the light register bank.
// Assumes short conversion counts for simulation.
module lrc_light_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lrc_pkg::*;

  localparam int SHORT = 20;
  localparam int LONG  = 50;

  logic        clock_i;
  logic        resetn_i;
  logic        bus_start;
  logic        bus_wr_valid;
  logic [7:0]  bus_wr_data;
  logic        bus_rd_req;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic [22:0] light_count;
  logic        conv_active;
  logic [3:0]  conv_range;
  logic [15:0] exp_q[$];
  logic [7:0]  msb_seen;
  logic        half;
  logic [16:0] r;
  logic [4:0]  lo;
  int          failures;
  int          checks;
  int          seed = 23;

  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  lrc_host_model i_lrc_host_model (
    .clock_i       (clock_i),
    .bus_start_o   (bus_start),
    .bus_wr_valid_o(bus_wr_valid),
    .bus_wr_data_o (bus_wr_data),
    .bus_rd_req_o  (bus_rd_req)
  );

  lrc_light_regs #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) i_lrc_light_regs (
    .clock_i       (clock_i),
    .resetn_i      (resetn_i),
    .bus_start_i   (bus_start),
    .bus_wr_valid_i(bus_wr_valid),
    .bus_wr_data_i (bus_wr_data),
    .bus_rd_req_i  (bus_rd_req),
    .bus_rd_data_o (rd_data),
    .bus_rd_valid_o(rd_valid),
    .light_count_i (light_count),
    .conv_active_o (conv_active),
    .conv_range_o  (conv_range)
  );

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [16:0] expect_conv(logic [3:0] rn, logic me, logic [22:0] c);
    int          e;
    logic [22:0] m;
    logic        ov;
    e = (rn == LRC_RN_AUTO) ? 0 : int'(rn);
    while (rn == LRC_RN_AUTO && e < 11 && (c >> e) > 4095)
      e++;
    m  = c >> e;
    ov = m > 4095;
    if (ov)
      m = 23'hfff;
    if (me && rn < LRC_RN_AUTO)
      e = 0;
    return {ov, 4'(e), m[11:0]};
  endfunction

  task automatic read(input logic [7:0] ptr, input logic [15:0] w);
    exp_q.push_back(w);
    i_lrc_host_model.read_reg(ptr);
    repeat (2) @(posedge clock_i);
    #1;
  endtask

  always @(posedge clock_i)
  begin
    if (rd_valid && !half)
      msb_seen = rd_data;
    else if (rd_valid)
      check("read word", {msb_seen, rd_data}, exp_q.pop_front());
    half = half ^ rd_valid;
  end

  initial
  begin
    resetn_i    = 1'b0;
    light_count = 23'h0;
    half        = 1'b0;
    failures    = 0;
    checks      = 0;
    repeat (2) @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    read(LRC_PTR_RESULT, LRC_RESULT_RST);
    read(LRC_PTR_CONFIG, LRC_CONFIG_RST);
    $display("test reset values done");
    for (int rn = 0; rn < 13; rn++)
    begin
      light_count = 23'($random(seed)) >> ((rn % 4) * 3);
      lo = 5'($random(seed));
      r  = expect_conv(4'(rn), lo[2], light_count);
      i_lrc_host_model.write_reg(LRC_PTR_CONFIG, {4'(rn), 3'b001, 4'hf, lo});
      if (rn < 12)
        check("conv range", 16'(conv_range), 16'(rn));
      repeat (SHORT + 10) @(posedge clock_i);
      read(LRC_PTR_RESULT, r[15:0]);
      read(LRC_PTR_CONFIG, {4'(rn), 3'b000, r[16], 3'b100, lo});
    end
    $display("test range sweep done");
    i_lrc_host_model.write_reg(LRC_PTR_CONFIG, {4'h5, 3'b111, 9'h000});
    check("conv active", 16'(conv_active), 16'h0001);
    light_count = ~light_count;
    repeat (20) @(posedge clock_i);
    i_lrc_host_model.write_reg(LRC_PTR_CONFIG, {4'h5, 3'b100, 9'h000});
    check("conv active", 16'(conv_active), 16'h0000);
    repeat (LONG + 10) @(posedge clock_i);
    read(LRC_PTR_RESULT, r[15:0]);
    read(LRC_PTR_CONFIG, {4'h5, 3'b100, r[16], 8'h00});
    $display("test abort done");
    report_and_stop();
  end

  initial
  begin
    #(4 * 20000);
    failures++;
    report_and_stop();
  end
endmodule
